// file: verilog/eepc_ctrl.sv
// serial eeprom command controller with avalon-mm register slave
//
// Function
// - writing one to busy starts the selected opcode at the held address.
// - busy stays set during the operation and self-clears; read data then valid.
// - opcode 000..111 is read, disable, enable, write, write all, erase, erase all, reload.
// - read fetches the addressed byte into the data register.
// - erase/write disable makes the eeprom ignore erase and write.
// - write programs the data byte at the address when enabled.
// - write all programs the data byte into every location.
// - erase clears the single addressed location.
// - erase all starts a bulk erase of the whole array.
// - reload reads byte zero and fails unless it equals A5h.
// - a failed reload leaves every register and descriptor untouched.
// - no eeprom response within 30 ms abandons the operation to idle.
// - timeout sets a sticky flag, reset zero, cleared by software write.
// - write to a missing eeprom with data input low keeps busy until the timeout, then clears.
// - with data input high and no part, commands finish without timeout.
// - with data input low and no part, only write and erase types time out.
// - data-loaded flag sets after a good load; reset zero, write clears.
// - address field is nine bits, byte granular, resets to zero.
// - data register holds one byte, write source and read destination.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

module eepc_ctrl
    import eepc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = EEPC_TO_CYCLES
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // avalon-mm register slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // three-wire serial eeprom pins
    output logic             eepromCs,
    output logic             eepromSclk,
    output logic             eepromSdo,
    input  wire logic        eeprom_serial_data_in
);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LEAD  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_GAP   = 3'b011,
        ST_POLL  = 3'b100,
        ST_DONE  = 3'b101
    } eepc_state_t;

    localparam logic [2:0]  PH_LAST = 3'(EEPC_SK_HALF_CYC - 1);
    localparam logic [19:0] TO_LAST = 20'(TIMEOUT_CYCLES - 1);

    eepc_state_t state;
    eepc_state_t next_state;
    eepc_op_t    eeprom_op_code;
    eepc_op_t    runOp;
    eepc_frame_t frame;

    logic        ack;
    logic        wrCmd;
    logic        wrData;
    logic        startSw;
    logic        startBoot;
    logic        bootPending;
    logic        eeprom_op_busy;
    logic [8:0]  eeprom_byte_address;
    logic [7:0]  eeprom_data_byte;
    logic        eeprom_timeout_flag;
    logic        eeprom_data_loaded;
    logic        sdiMeta;
    logic        sdiSync;
    logic [2:0]  phase;
    logic        phEnd;
    logic [19:0] toCnt;
    logic        toHit;
    logic [19:0] txShift;
    logic [7:0]  rxShift;
    logic [4:0]  bitIdx;
    logic        lastBit;
    logic        selCmd;
    logic        selData;
    logic        clrTo;
    logic        clrDl;
    logic        readDone;
    logic        loadGood;
    logic        pollArmed;
    logic [31:0] statusWord;

    // bus handshake: every access waits one cycle, so read data come from a flop
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wrCmd  = avs_write & ack & selCmd;
    assign wrData = avs_write & ack & selData;

    // register selects, shared by the read mux and the write strobes
    assign selCmd  = (avs_address == EEPC_CMD_OFF);
    assign selData = (avs_address == EEPC_DATA_OFF);

    // status word as software reads it at the command offset
    assign statusWord = {eeprom_op_busy, eeprom_op_code, 17'h00000,
                         eeprom_timeout_flag, eeprom_data_loaded,
                         eeprom_byte_address};

    // opcode field of a command write, used by the register and the run latch
    function automatic eepc_op_t opField(logic [31:0] wd);
        return eepc_op_t'(wd[EEPC_OP_LSB +: 3]);
    endfunction

    // ack marks the second cycle of an access, the one that completes it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    // read mux, captured in the first cycle of the access; unmapped reads zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack) begin
            if (selCmd) begin
                avs_readdata <= statusWord;
            end else if (selData) begin
                avs_readdata <= {24'h000000, eeprom_data_byte};
            end else begin
                avs_readdata <= 32'h00000000;
            end
        end
    end

    // a command starts from software, or once after reset as the power-up load
    assign eeprom_op_busy = (state != ST_IDLE);
    assign startSw   = wrCmd & avs_byteenable[3] & avs_writedata[EEPC_BUSY_BIT]
                     & ~eeprom_op_busy;
    assign startBoot = bootPending & ~eeprom_op_busy & ~startSw;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bootPending <= 1'b1;
        end else if (startBoot) begin
            bootPending <= 1'b0;
        end
    end

    // command fields; writes while busy are dropped so a running frame stays intact
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            eeprom_op_code      <= OP_READ;
            eeprom_byte_address <= EEPC_ADDR_RST;
        end else if (wrCmd && !eeprom_op_busy) begin
            if (avs_byteenable[3]) begin
                eeprom_op_code <= opField(avs_writedata);
            end
            if (avs_byteenable[1]) begin
                eeprom_byte_address[8] <= avs_writedata[8];
            end
            if (avs_byteenable[0]) begin
                eeprom_byte_address[7:0] <= avs_writedata[7:0];
            end
        end
    end

    // operation latched at start; the power-up load is a reload
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            runOp <= OP_READ;
        end else if (startSw) begin
            runOp <= opField(avs_writedata);
        end else if (startBoot) begin
            runOp <= OP_RELOAD;
        end
    end

    // flag clears act even while busy; completion events last one cycle
    assign clrTo    = wrCmd & avs_byteenable[1] & avs_writedata[EEPC_TO_BIT];
    assign clrDl    = wrCmd & avs_byteenable[1] & avs_writedata[EEPC_DL_BIT];
    assign readDone = (state == ST_DONE) && (runOp == OP_READ);
    assign loadGood = (state == ST_DONE) && (runOp == OP_RELOAD)
                    && (rxShift == EEPC_SIGNATURE);

    // data byte: write source, read destination
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            eeprom_data_byte <= EEPC_DATA_RST;
        end else if (readDone) begin
            eeprom_data_byte <= rxShift;
        end else if (wrData && !eeprom_op_busy && avs_byteenable[0]) begin
            eeprom_data_byte <= avs_writedata[7:0];
        end
    end

    // sticky flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            eeprom_timeout_flag <= 1'b0;
        end else if (toHit) begin
            eeprom_timeout_flag <= 1'b1;
        end else if (clrTo) begin
            eeprom_timeout_flag <= 1'b0;
        end
    end

    // data-loaded: set by a good signature on the power-up load or a reload
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            eeprom_data_loaded <= 1'b0;
        end else if (loadGood) begin
            eeprom_data_loaded <= 1'b1;
        end else if (clrDl) begin
            eeprom_data_loaded <= 1'b0;
        end
    end
    // a bad signature changes nothing at all: no flag, no data byte

    // data-in pin crosses in through two flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sdiMeta <= 1'b0;
            sdiSync <= 1'b0;
        end else begin
            sdiMeta <= eeprom_serial_data_in;
            sdiSync <= sdiMeta;
        end
    end

    // instruction for the running operation; registers are frozen while busy
    assign frame   = eepc_frame(runOp, eeprom_byte_address, eeprom_data_byte);
    assign phEnd   = (phase == PH_LAST);
    assign lastBit = (bitIdx == frame.total - 5'h01);

    // timeout runs from the start of every operation; a programming cycle
    // longer than the limit is reported as a failure even if it completes
    assign toHit = eeprom_op_busy && (toCnt == TO_LAST);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            toCnt <= 20'h00000;
        end else if (!eeprom_op_busy) begin
            toCnt <= 20'h00000;
        end else begin
            toCnt <= toCnt + 20'h00001;
        end
    end

    // half-period counter of the serial clock, restarted on every state change
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 3'h0;
        end else if (next_state != state || phEnd) begin
            phase <= 3'h0;
        end else begin
            phase <= phase + 3'h1;
        end
    end

    // a deselected part leaves the data line floating, and the sync flops
    // still hold that level when select returns, so ready is only trusted
    // after one full half period in the poll state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pollArmed <= 1'b0;
        end else begin
            pollArmed <= (state == ST_POLL) && (pollArmed || phEnd);
        end
    end

    // sequencer: lead-in with select low, shift, then ready poll for programming
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (startSw || startBoot) begin
                    next_state = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (phEnd) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (phEnd && eepromSclk && lastBit) begin
                    // only programming instructions wait for ready
                    next_state = frame.poll ? ST_GAP : ST_DONE;
                end
            end
            ST_GAP: begin
                if (phEnd) begin
                    next_state = ST_POLL;
                end
            end
            ST_POLL: begin
                // a part still programming holds the line low
                if (sdiSync && pollArmed) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                // one cycle for the data byte to land before busy drops
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (toHit) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // chip select from a flop: high while shifting and while polling ready
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            eepromCs <= 1'b0;
        end else begin
            eepromCs <= (next_state == ST_SHIFT) || (next_state == ST_POLL);
        end
    end

    // shift engine: data out changes on falling sclk, data in sampled on rising
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            eepromSclk <= 1'b0;
            txShift    <= 20'h00000;
            rxShift    <= 8'h00;
            bitIdx     <= 5'h00;
        end else if (toHit) begin
            // an abort parks the clock low so the part sees no stray edge
            eepromSclk <= 1'b0;
            txShift    <= 20'h00000;
            bitIdx     <= 5'h00;
        end else if (state == ST_LEAD && phEnd) begin
            txShift <= frame.bits;
            bitIdx  <= 5'h00;
        end else if (state == ST_SHIFT && phEnd) begin
            eepromSclk <= ~eepromSclk;
            if (!eepromSclk) begin
                if (frame.rx && bitIdx >= EEPC_SEND_SHORT) begin
                    rxShift <= {rxShift[6:0], sdiSync};
                end
            end else begin
                txShift <= {txShift[18:0], 1'b0};
                bitIdx  <= bitIdx + 5'h01;
            end
        end
    end

    // the frame is zero padded, so the line idles low once the bits are out
    assign eepromSdo = txShift[19];
    // erase and erase-all frames carry no data byte
    // write enable and disable frames change the part's own lock

endmodule // eepc_ctrl

`default_nettype wire

// file: verilog/eepc_pkg.sv
// constants, types and frame builder for the serial eeprom command controller
package eepc_pkg;
    // register map, byte addresses
    localparam logic [7:0] EEPC_CMD_OFF  = 8'h40;
    localparam logic [7:0] EEPC_DATA_OFF = 8'h44;
    // command register field positions
    localparam int EEPC_BUSY_BIT = 31;
    localparam int EEPC_OP_LSB   = 28;
    localparam int EEPC_TO_BIT   = 10;
    localparam int EEPC_DL_BIT   = 9;
    // reset values
    localparam logic [8:0] EEPC_ADDR_RST = 9'h000;
    localparam logic [7:0] EEPC_DATA_RST = 8'h00;
    // signature that marks a programmed part
    localparam logic [7:0] EEPC_SIGNATURE = 8'hA5;
    // serial frame lengths: start + opcode + address, and with a data byte
    localparam logic [4:0] EEPC_SEND_SHORT = 5'h0C;
    localparam logic [4:0] EEPC_SEND_LONG  = 5'h14;
    // timing
    localparam int EEPC_CLK_NS     = 40;
    localparam int EEPC_SK_HALF_NS = 320;
    localparam int EEPC_SK_HALF_CYC =
        (EEPC_SK_HALF_NS + EEPC_CLK_NS - 1) / EEPC_CLK_NS;
    localparam int EEPC_TO_MS = 30;
    localparam int EEPC_TO_CYCLES = EEPC_TO_MS * 1000000 / EEPC_CLK_NS;

    typedef enum logic [2:0] {
        OP_READ   = 3'b000,
        OP_LOCK   = 3'b001,
        OP_UNLOCK = 3'b010,
        OP_WRITE  = 3'b011,
        OP_WR_ALL = 3'b100,
        OP_ERASE  = 3'b101,
        OP_ER_ALL = 3'b110,
        OP_RELOAD = 3'b111
    } eepc_op_t;

    // one serial instruction: bits msb first, length, read-back, ready poll
    typedef struct packed {
        logic [19:0] bits;
        logic [4:0]  total;
        logic        rx;
        logic        poll;
    } eepc_frame_t;

    // decode a command into its three-wire instruction
    function automatic eepc_frame_t eepc_frame(eepc_op_t op, logic [8:0] a,
                                               logic [7:0] d);
        eepc_frame_t f;
        f = '{bits: 20'h00000, total: EEPC_SEND_SHORT, rx: 1'b0, poll: 1'b0};
        unique case (op)
            OP_READ:   f = '{{3'b110, a, 8'h00}, EEPC_SEND_LONG, 1'b1, 1'b0};
            OP_LOCK:   f.bits = {3'b100, 9'h000, 8'h00};
            OP_UNLOCK: f.bits = {3'b100, 9'h180, 8'h00};
            OP_WRITE:  f = '{{3'b101, a, d}, EEPC_SEND_LONG, 1'b0, 1'b1};
            OP_WR_ALL: f = '{{3'b100, 9'h080, d}, EEPC_SEND_LONG, 1'b0, 1'b1};
            OP_ERASE:  f = '{{3'b111, a, 8'h00}, EEPC_SEND_SHORT, 1'b0, 1'b1};
            OP_ER_ALL: f = '{{3'b100, 9'h100, 8'h00}, EEPC_SEND_SHORT, 1'b0, 1'b1};
            OP_RELOAD: f = '{{3'b110, 9'h000, 8'h00}, EEPC_SEND_LONG, 1'b1, 1'b0};
        endcase
        return f;
    endfunction
endpackage

// file: testbench/eepc_monitor.sv
// port-level assertion checker for the eeprom command controller
`timescale 1ns/100ps
`default_nettype none
module eepc_monitor
    import eepc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = EEPC_TO_CYCLES
) (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // register bus
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // serial pins
    input wire logic        eepromCs,
    input wire logic        eepromSclk,
    input wire logic        eepromSdo,
    input wire logic        eeprom_serial_data_in
);
    int   csRun;
    int   bitCnt;
    logic sclkQ;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // select run length and clock rise count, both cleared when select drops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            csRun <= 0;
            bitCnt <= 0;
            sclkQ <= 1'b0;
        end else begin
            csRun <= eepromCs ? csRun + 1 : 0;
            bitCnt <= eepromCs ? bitCnt + int'(eepromSclk && !sclkQ) : 0;
            sclkQ <= eepromSclk;
        end
    end
    sequence s_rdDone(logic [7:0] a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    sequence s_start;
        avs_write && !avs_waitrequest && avs_address == EEPC_CMD_OFF
            && avs_byteenable[3] && avs_writedata[EEPC_BUSY_BIT];
    endsequence
    AST_ONE_WAIT: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus access held more than one wait cycle");
    AST_IDLE_NOWAIT: assert property (
        !(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high with no access");
    AST_START_FRAME: assert property (
        s_start |-> ##[1:16] eepromCs)
        else $error("start command raised no chip select");
    AST_IDLE_DESELECT: assert property (
        s_rdDone(EEPC_CMD_OFF) ##0 !avs_readdata[EEPC_BUSY_BIT] |-> !eepromCs)
        else $error("busy read clear while the part is selected");
    AST_CMD_RESERVED: assert property (
        s_rdDone(EEPC_CMD_OFF) |-> avs_readdata[27:11] == 17'h00000)
        else $error("reserved command bits read nonzero");
    AST_DATA_BYTE: assert property (
        s_rdDone(EEPC_DATA_OFF) |-> avs_readdata[31:8] == 24'h000000)
        else $error("data register wider than a byte");
    AST_SCLK_HALF: assert property (
        $changed(eepromSclk) |=> $stable(eepromSclk) [*7])
        else $error("serial clock half period shorter than eight cycles");
    AST_SDO_ON_FALL: assert property (
        eepromCs && $past(eepromCs) && $changed(eepromSdo) |-> $fell(eepromSclk))
        else $error("serial data changed away from a clock fall");
    AST_START_BIT: assert property (
        $rose(eepromSclk) && eepromCs && bitCnt == 0 |-> eepromSdo)
        else $error("first bit of a frame is not a one");
    AST_TIMEOUT_BOUND: assert property (
        csRun <= int'(TIMEOUT_CYCLES))
        else $error("part selected beyond the timeout");
endmodule // eepc_monitor
bind eepc_ctrl eepc_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mon (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .eepromCs(eepromCs),
    .eepromSclk(eepromSclk), .eepromSdo(eepromSdo),
    .eeprom_serial_data_in(eeprom_serial_data_in));
`default_nettype wire

// file: testbench/eepc_eeprom_model.sv
// behavioural three-wire serial eeprom, 512 bytes, with erase/write latch
`timescale 1ns/100ps
`default_nettype none
module eepc_eeprom_model #(
    parameter int PROG_NS = 2000
) (
    // three-wire pins
    input  wire logic cs,
    input  wire logic sk,
    input  wire logic di,
    output logic      dout
);
    logic [7:0]  mem [512];
    logic [19:0] sh;
    logic [7:0]  rd;
    logic        q;
    logic        wen;
    logic        rdMode;
    logic        prog;
    int          n;
    // power-up: programming locked, signature in byte zero, rest erased
    initial begin
        wen = 1'b0;
        q = 1'b1;
        n = 0;
        rdMode = 1'b0;
        foreach (mem[i]) mem[i] = 8'hFF;
        mem[0] = 8'hA5;
    end
    // a deselected part shows the inverse, so nothing may rely on a held level
    assign dout = cs ? q : ~q;
    // shift in on rise; a read streams the byte out from bit 12 on
    always @(posedge sk) begin
        if (cs) begin
            sh = {sh[18:0], di};
            n = n + 1;
            if (n == 12 && sh[10:9] == 2'b10) begin
                rdMode = 1'b1;
                rd = mem[sh[8:0]];
                q = rd[7];
            end else if (rdMode && n > 12) begin
                rd = rd << 1;
                q = rd[7];
            end
        end
    end
    // decode on deselect; programming holds ready low for a while
    always @(negedge cs) begin
        prog = 1'b0;
        if (n == 12 && sh[10:7] == 4'b0000)
            wen = 1'b0;
        if (n == 12 && sh[10:7] == 4'b0011)
            wen = 1'b1;
        if (wen && n == 20 && sh[18:17] == 2'b01) begin
            mem[sh[16:8]] = sh[7:0];
            prog = 1'b1;
        end
        if (wen && n == 20 && sh[18:15] == 4'b0001) begin
            foreach (mem[i]) mem[i] = sh[7:0];
            prog = 1'b1;
        end
        if (wen && n == 12 && sh[10:9] == 2'b11) begin
            mem[sh[8:0]] = 8'hFF;
            prog = 1'b1;
        end
        if (wen && n == 12 && sh[10:7] == 4'b0010) begin
            foreach (mem[i]) mem[i] = 8'hFF;
            prog = 1'b1;
        end
        if (prog) begin
            q = 1'b0;
            q <= #PROG_NS 1'b1;
        end else begin
            q = 1'b1; // nothing to program: ready at once
        end
        n = 0;
        rdMode = 1'b0;
    end
endmodule // eepc_eeprom_model
`default_nettype wire

// file: testbench/eepc_ctrl_tb_top.sv
// self-checking bench for the eeprom command controller
`timescale 1ns/100ps
`default_nettype none
module eepc_ctrl_tb_top
    import eepc_pkg::*;
;
    localparam int TO_CYC = 1200; // shortened so a timeout stays quick
    logic        mclk;
    logic        rst_n;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        eepromCs;
    logic        eepromSclk;
    logic        eepromSdo;
    logic        partSdi;
    logic        present;
    logic        pullLvl;
    logic [31:0] rv;
    int          mismatches;
    int          comparisons;
    int          cyc;
    int          t0;
    // with no part fitted the data line sits at its pull level
    wire logic   sdiWire = present ? partSdi : pullLvl;
    eepc_ctrl #(.TIMEOUT_CYCLES(TO_CYC)) uut (
        .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .eepromCs(eepromCs), .eepromSclk(eepromSclk), .eepromSdo(eepromSdo),
        .eeprom_serial_data_in(sdiWire));
    eepc_eeprom_model part (.cs(eepromCs), .sk(eepromSclk), .di(eepromSdo), .dout(partSdi));
    // 25 MHz clock and a free cycle count
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial cyc = 0;
    always @(posedge mclk) cyc <= cyc + 1;
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
        int i;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 20);
        rv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            chk("bus answer", 32'h0, 32'h1);
            close_out();
        end
    endtask
    // poll busy under a bound; rv ends as the last status word
    task automatic waitIdle();
        int i;
        i = 0;
        do begin
            bus(1'b0, EEPC_CMD_OFF, 32'h0);
            i++;
        end while (rv[EEPC_BUSY_BIT] !== 1'b0 && i < 2000);
        if (rv[EEPC_BUSY_BIT] !== 1'b0) begin
            chk("busy clear", 32'h0, 32'h1);
            close_out();
        end
    endtask
    task automatic cmd(logic [2:0] op, logic [8:0] a);
        bus(1'b1, EEPC_CMD_OFF, {1'b1, op, 19'h00000, a});
        waitIdle();
    endtask
    task automatic rdByte(logic [8:0] a, logic [7:0] e, string nm);
        cmd(OP_READ, a);
        bus(1'b0, EEPC_DATA_OFF, 32'h0);
        chk(nm, {24'h000000, e}, rv);
    endtask
    initial begin
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        present = 1'b1;
        pullLvl = 1'b1;
        mismatches = 0;
        comparisons = 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        waitIdle();
        chk("status after load", 32'h0000_0200, rv);
        bus(1'b0, 8'h48, 32'h0);
        chk("unmapped read", 32'h0, rv);
        bus(1'b1, EEPC_DATA_OFF, 32'hFFFF_FF5A);
        bus(1'b0, EEPC_DATA_OFF, 32'h0);
        chk("data register", 32'h0000_005A, rv);
        cmd(OP_WRITE, 9'h003);
        rdByte(9'h003, 8'hFF, "write while locked");
        $display("test reset and lock done");
        cmd(OP_UNLOCK, 9'h000);
        bus(1'b1, EEPC_DATA_OFF, 32'h0000_005A);
        cmd(OP_WRITE, 9'h1FF);
        rdByte(9'h1FF, 8'h5A, "top byte");
        cmd(OP_ERASE, 9'h1FF);
        rdByte(9'h1FF, 8'hFF, "erased byte");
        bus(1'b1, EEPC_DATA_OFF, 32'h0000_003C);
        cmd(OP_WR_ALL, 9'h000);
        rdByte(9'h100, 8'h3C, "write all");
        cmd(OP_ER_ALL, 9'h000);
        rdByte(9'h000, 8'hFF, "erase all");
        cmd(OP_LOCK, 9'h000);
        bus(1'b1, EEPC_DATA_OFF, 32'h0000_0011);
        cmd(OP_WRITE, 9'h005);
        rdByte(9'h005, 8'hFF, "write after lock");
        $display("test program and erase done");
        bus(1'b1, EEPC_CMD_OFF, 32'h0000_0200);
        bus(1'b1, EEPC_DATA_OFF, 32'h0000_0077);
        cmd(OP_RELOAD, 9'h000);
        chk("failed reload status", 32'h7000_0000, rv);
        bus(1'b0, EEPC_DATA_OFF, 32'h0);
        chk("data after failed reload", 32'h0000_0077, rv);
        cmd(OP_UNLOCK, 9'h000);
        bus(1'b1, EEPC_DATA_OFF, {24'h000000, EEPC_SIGNATURE});
        cmd(OP_WRITE, 9'h000);
        cmd(OP_RELOAD, 9'h000);
        chk("good reload status", 32'h7000_0200, rv);
        $display("test reload done");
        present <= 1'b0;
        pullLvl <= 1'b0;
        cmd(OP_READ, 9'h000);
        chk("read with low line", 32'h0, rv & 32'h8000_0400);
        t0 = cyc;
        cmd(OP_WRITE, 9'h001);
        chk("write timed out", 32'h3000_0601, rv);
        chk("busy held to timeout", 32'h1, 32'(cyc - t0 >= TO_CYC && cyc - t0 <= TO_CYC + 12));
        bus(1'b1, EEPC_CMD_OFF, 32'h0000_0400);
        bus(1'b0, EEPC_CMD_OFF, 32'h0);
        chk("timeout cleared", 32'h0000_0200, rv);
        pullLvl <= 1'b1;
        t0 = cyc;
        cmd(OP_WRITE, 9'h001);
        chk("high line no timeout", 32'h3000_0201, rv);
        chk("high line prompt", 32'h1, 32'(cyc - t0 < TO_CYC / 2));
        $display("test missing part done");
        close_out();
    end
endmodule // eepc_ctrl_tb_top
`default_nettype wire
